// ---- hdl/adc_seq_pkg.sv ----
// Behaviour
// - 10-bit results, 16+8 channels, one sample-hold
// - software programs sample and conversion durations
// - one select bit chooses input pin group
// - overrun raises request when unread result overwritten
// - alternative: next conversion waits for read
// - unused analog inputs readable as digital pins
// - single mode converts selected channel once
// - continuous mode repeats selected channel forever
// - auto-scan single converts selected channel down to channel 0, each once
// - each scan result can trigger transfer request
// - auto-scan continuous repeats scan indefinitely
// - wait-for-read buffers result and pauses conversion, in continuous modes only
// - injected conversion inserted during continuous mode
// - injected result goes to second result register
// - continuous mode resumes after injection
// - post-reset calibration, busy high, bounded length
// - no conversion while calibration runs
// - calibration reruns after every reset, never otherwise
package adc_seq_pkg;
    // register byte offsets
    localparam logic [4:0] CTRL_OFS   = 5'h00;
    localparam logic [4:0] RESULT_OFS = 5'h04;
    localparam logic [4:0] INJECT_OFS = 5'h08;
    localparam logic [4:0] TIMING_OFS = 5'h0c;
    localparam logic [4:0] STATUS_OFS = 5'h10;
    localparam logic [4:0] PINS_OFS   = 5'h14;
    // control field positions
    localparam int CTRL_CH_LSB  = 0;   // 5-bit channel
    localparam int CTRL_MODE_LSB = 5;  // 2-bit mode
    localparam int CTRL_START   = 7;   // write 1 starts
    localparam int CTRL_WAITRD  = 8;   // wait_for_read_enable
    localparam int CTRL_GRPSEL  = 9;   // pin group select
    localparam int CTRL_STALLOV = 10;  // 1 stall, 0 overrun irq
    localparam int CTRL_INJREQ  = 11;  // write 1 injects
    localparam int CTRL_INJCH_LSB = 12; // 5-bit injected channel
    localparam int CTRL_STOP    = 17;  // write 1 stops continuous
    // status bits
    localparam int ST_BUSY = 0;
    localparam int ST_CAL  = 1;
    localparam int ST_OVR  = 2;
    localparam int ST_FULL = 3;
    localparam int ST_INJD = 4;
    localparam int ST_RUN  = 5;
    localparam int RES_W   = 10;
    localparam int NCH     = 24;
    localparam logic [4:0] NCH_MAX = 5'd23;
    // calibration: at most 40630 cpu cycles
    localparam int CAL_CYCLES_DOC = 40630;
    localparam int CAL_CYCLES_DEF = CAL_CYCLES_DOC;
    localparam logic [7:0]  SAMPLE_RST = 8'h08;
    localparam logic [7:0]  CONV_RST   = 8'h0c;
    typedef enum logic [1:0] {
        MODE_SINGLE, MODE_CONT, MODE_SCAN, MODE_SCANCONT
    } mode_e;
    typedef enum logic [2:0] {
        S_CAL, S_IDLE, S_SAMPLE, S_CONVERT, S_STORE, S_HOLD
    } state_e;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [4:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;
endpackage : adc_seq_pkg

// ---- hdl/adc_sequencer_control.sv ----
// The placing of the registers and register access over Wishbone were decided locally.
module adc_sequencer_control #(
    parameter int CAL_CYCLES = adc_seq_pkg::CAL_CYCLES_DEF
) (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // wishbone slave
    input  wire adc_seq_pkg::wb_req_s    wbReq,
    output adc_seq_pkg::wb_rsp_s         wbRsp,
    // analog front end
    output logic [4:0]                   anaChannel,
    output logic                         anaGroupSel,
    output logic                         anaSample,
    output logic                         anaConvert,
    input  wire logic [9:0]              anaResult,
    input  wire logic [23:0]             pinLevels,
    // system events
    output logic                         overrunIrq,
    output logic                         resultIrq,
    output logic                         transferReq
);
    import adc_seq_pkg::*;

    typedef struct packed {
        state_e      st;
        logic [15:0] cnt;
        logic [4:0]  chan;
        logic [4:0]  scanCh;
        mode_e       mode;
        logic        waitRd;
        logic        grpSel;
        logic        stallOv;
        logic        running;
        logic        injPend;
        logic [4:0]  injCh;
        logic        injActive;
        logic [7:0]  sampleT;
        logic [7:0]  convT;
        logic [9:0]  result;
        logic        resFull;
        logic [9:0]  tempBuf;
        logic        tempFull;
        logic [9:0]  injResult;
        logic        injDone;
        logic        overrun;
        logic        busy;
        logic        ovrPulse;
        logic        resPulse;
        logic        ack;
        logic [31:0] rdat;
    } state_s;

    state_s cur_reg;
    state_s cur_next;

    // next channel in the scan, counting down to zero
    function automatic logic [4:0] scanNext(input logic [4:0] ch);
        scanNext = (ch == 5'd0) ? 5'd0 : ch - 5'd1;
    endfunction : scanNext

    function automatic logic [4:0] clampCh(input logic [4:0] ch);
        clampCh = (ch > NCH_MAX) ? NCH_MAX : ch;
    endfunction : clampCh

    logic wbAccess;
    logic wrStrobe;
    logic rdResult;
    logic rdInject;
    logic [31:0] statusWord;

    // one-cycle answer; ack drops the cycle after it was given
    assign wbAccess = wbReq.cyc & wbReq.stb & ~cur_reg.ack;
    // writes land on the acknowledged edge, where the master completes the cycle
    assign wrStrobe = wbReq.cyc & wbReq.stb & wbReq.we & cur_reg.ack;
    assign rdResult = wbAccess & ~wbReq.we & (wbReq.adr == RESULT_OFS);
    assign rdInject = wbAccess & ~wbReq.we & (wbReq.adr == INJECT_OFS);

    assign statusWord = {26'h0, cur_reg.running, cur_reg.injDone, cur_reg.resFull,
                         cur_reg.overrun, (cur_reg.st == S_CAL), cur_reg.busy};

    always_comb begin
        state_s n;
        logic   doneConv;
        logic [9:0] newRes;
        logic       injSet;
        n = cur_reg;
        doneConv = 1'b0;
        injSet = 1'b0;
        newRes = anaResult;
        n.ovrPulse = 1'b0;
        n.resPulse = 1'b0;
        n.ack = wbAccess;

        // register writes
        if (wrStrobe) begin
            unique case (wbReq.adr)
                CTRL_OFS: begin
                    if (wbReq.sel[0]) begin
                        n.chan = clampCh(wbReq.dat[CTRL_CH_LSB +: 5]);
                        n.mode = mode_e'(wbReq.dat[CTRL_MODE_LSB +: 2]);
                    end
                    if (wbReq.sel[1]) begin
                        n.waitRd  = wbReq.dat[CTRL_WAITRD];
                        n.grpSel  = wbReq.dat[CTRL_GRPSEL];
                        n.stallOv = wbReq.dat[CTRL_STALLOV];
                        if (wbReq.dat[CTRL_INJREQ] && cur_reg.running
                            && (cur_reg.mode == MODE_CONT || cur_reg.mode == MODE_SCANCONT))
                            injSet = 1'b1;
                    end
                    if (wbReq.sel[1] && wbReq.sel[2])
                        n.injCh = clampCh(wbReq.dat[CTRL_INJCH_LSB +: 5]);
                    if (wbReq.sel[2] && wbReq.dat[CTRL_STOP])
                        n.running = 1'b0;
                    // start ignored during calibration
                    if (wbReq.sel[0] && wbReq.dat[CTRL_START] && cur_reg.st != S_CAL) begin
                        n.running = 1'b1;
                        n.scanCh = clampCh(wbReq.dat[CTRL_CH_LSB +: 5]);
                    end
                end
                TIMING_OFS: begin
                    if (wbReq.sel[0]) n.sampleT = wbReq.dat[7:0];
                    if (wbReq.sel[1]) n.convT = wbReq.dat[15:8];
                end
                STATUS_OFS: begin
                    // write 1 clears overrun
                    if (wbReq.sel[0] && wbReq.dat[ST_OVR]) n.overrun = 1'b0;
                end
                default: ;
            endcase
        end

        // reading results frees the result register
        if (rdResult) begin
            n.resFull = 1'b0;
            if (cur_reg.tempFull) begin
                n.result = cur_reg.tempBuf;
                n.resFull = 1'b1;
                n.tempFull = 1'b0;
                n.resPulse = 1'b1;
            end
        end
        if (rdInject) n.injDone = 1'b0;

        // sequencer
        unique case (cur_reg.st)
            S_CAL: begin
                n.busy = 1'b1;
                if (cur_reg.cnt == 16'(CAL_CYCLES - 1)) begin
                    n.st = S_IDLE;
                    n.busy = 1'b0;
                    n.cnt = '0;
                end else begin
                    n.cnt = cur_reg.cnt + 16'd1;
                end
            end
            S_IDLE: begin
                // stall mode waits for a read before converting
                if (cur_reg.running && !(cur_reg.stallOv && cur_reg.resFull)
                    && !cur_reg.tempFull) begin
                    n.st = S_SAMPLE;
                    n.cnt = '0;
                    n.busy = 1'b1;
                    n.injActive = cur_reg.injPend;
                    n.injPend = 1'b0;
                end
            end
            S_SAMPLE: begin
                n.cnt = cur_reg.cnt + 16'd1;
                if (cur_reg.cnt[7:0] >= cur_reg.sampleT) begin
                    n.st = S_CONVERT;
                    n.cnt = '0;
                end
            end
            S_CONVERT: begin
                n.cnt = cur_reg.cnt + 16'd1;
                if (cur_reg.cnt[7:0] >= cur_reg.convT) begin
                    n.st = S_STORE;
                    n.cnt = '0;
                end
            end
            S_STORE: begin
                doneConv = 1'b1;
                n.busy = 1'b0;
                n.st = S_IDLE;
                if (cur_reg.injActive) begin
                    n.injResult = newRes;
                    n.injDone = 1'b1;
                    n.injActive = 1'b0;
                end else begin
                    if (cur_reg.resFull && !rdResult && cur_reg.waitRd
                        && (cur_reg.mode == MODE_CONT || cur_reg.mode == MODE_SCANCONT)) begin
                        n.tempBuf = newRes;
                        n.tempFull = 1'b1;
                    end else begin
                        if (cur_reg.resFull && !rdResult && !cur_reg.stallOv) begin
                            n.overrun = 1'b1;
                            n.ovrPulse = 1'b1;
                        end
                        n.result = newRes;
                        n.resFull = 1'b1;
                        n.resPulse = 1'b1;
                    end
                    unique case (cur_reg.mode)
                        MODE_SINGLE: n.running = 1'b0;
                        MODE_CONT: ;
                        MODE_SCAN: begin
                            if (cur_reg.scanCh == 5'd0) n.running = 1'b0;
                            n.scanCh = scanNext(cur_reg.scanCh);
                        end
                        MODE_SCANCONT: n.scanCh = (cur_reg.scanCh == 5'd0)
                                                  ? cur_reg.chan : scanNext(cur_reg.scanCh);
                    endcase
                end
            end
            S_HOLD: n.st = S_IDLE;
        endcase
        if (doneConv && n.st == S_IDLE && cur_reg.injActive) n.st = S_IDLE;
        // set wins: a request landing as a conversion starts waits for the next
        if (injSet) n.injPend = 1'b1;

        // read data
        unique case (wbReq.adr)
            CTRL_OFS:   n.rdat = {15'h0, cur_reg.injCh, 1'b0, cur_reg.stallOv, cur_reg.grpSel,
                                  cur_reg.waitRd, cur_reg.running, cur_reg.mode, cur_reg.chan};
            RESULT_OFS: n.rdat = {22'h0, cur_reg.result};
            INJECT_OFS: n.rdat = {22'h0, cur_reg.injResult};
            TIMING_OFS: n.rdat = {16'h0, cur_reg.convT, cur_reg.sampleT};
            STATUS_OFS: n.rdat = statusWord;
            PINS_OFS:   n.rdat = {8'h0, pinLevels};
            default:    n.rdat = 32'h0;
        endcase
        cur_next = n;
    end

    // single register stage holds all state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '{st: S_CAL, busy: 1'b1, sampleT: SAMPLE_RST, convT: CONV_RST,
                         mode: MODE_SINGLE, default: '0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    // outputs straight from state
    assign wbRsp.ack   = cur_reg.ack;
    assign wbRsp.dat   = cur_reg.rdat;
    assign anaChannel  = cur_reg.injActive ? cur_reg.injCh
                       : ((cur_reg.mode == MODE_SCAN || cur_reg.mode == MODE_SCANCONT)
                          ? cur_reg.scanCh : cur_reg.chan);
    assign anaGroupSel = cur_reg.grpSel;
    assign anaSample   = (cur_reg.st == S_SAMPLE);
    assign anaConvert  = (cur_reg.st == S_CONVERT);
    assign overrunIrq  = cur_reg.ovrPulse;
    assign resultIrq   = cur_reg.resPulse;
    assign transferReq = cur_reg.resPulse;
endmodule : adc_sequencer_control

// ---- sim/adc_sequencer_control_sva.sv ----
module adc_sequencer_control_sva
    import adc_seq_pkg::*;
#(
    parameter int CAL_CYCLES = 20
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    // bus
    input wire adc_seq_pkg::wb_req_s wbReq,
    input wire adc_seq_pkg::wb_rsp_s wbRsp,
    // front end and events
    input wire logic [4:0]           anaChannel,
    input wire logic                 anaSample,
    input wire logic                 anaConvert,
    input wire logic                 overrunIrq,
    input wire logic                 resultIrq,
    input wire logic                 transferReq
);
    timeunit 1ns;
    timeprecision 1ps;
    int calCnt_reg;
    // cycles since reset release, saturating at the calibration length
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) calCnt_reg <= 0;
        else if (calCnt_reg < CAL_CYCLES) calCnt_reg <= calCnt_reg + 1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // bus answer timing, front end sequencing and event outputs
    ack_latency_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack held longer than one cycle");
    cal_quiet_a: assert property (calCnt_reg < CAL_CYCLES |-> !anaSample && !anaConvert)
        else $error("conversion during calibration");
    chan_range_a: assert property (anaChannel <= NCH_MAX)
        else $error("channel out of range");
    phase_excl_a: assert property (!(anaSample && anaConvert))
        else $error("sample and convert together");
    conv_order_a: assert property ($rose(anaConvert) |-> $past(anaSample))
        else $error("convert without prior sample");
    event_pair_a: assert property (resultIrq == transferReq)
        else $error("transfer request differs from result event");
    result_pulse_a: assert property (resultIrq |=> !resultIrq)
        else $error("result event longer than one cycle");
    overrun_pulse_a: assert property (overrunIrq |=> !overrunIrq)
        else $error("overrun event longer than one cycle");
    // main scenarios reached
    cover property ($rose(anaSample));
    cover property (overrunIrq);
    cover property (resultIrq);
endmodule : adc_sequencer_control_sva

// ---- sim/test_adc_sequencer_control.sv ----
module test_adc_sequencer_control;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;
    localparam int CAL = 20;
    logic sys_clk, rst_n, anaGroupSel, anaSample, anaConvert, overrunIrq, resultIrq, transferReq;
    wb_req_s     wbReq;
    wb_rsp_s     wbRsp;
    logic [4:0]  anaChannel;
    logic [9:0]  anaResult;
    logic [23:0] pinLevels;
    logic [15:0] seed;
    logic [63:0] notes[$];
    int          fails, n_checks, nIrq, nOvr;

    adc_sequencer_control #(.CAL_CYCLES(CAL)) u_adc_sequencer_control (
        .sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
        .anaChannel(anaChannel), .anaGroupSel(anaGroupSel), .anaSample(anaSample),
        .anaConvert(anaConvert), .anaResult(anaResult), .pinLevels(pinLevels),
        .overrunIrq(overrunIrq), .resultIrq(resultIrq), .transferReq(transferReq));

    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // one classic cycle; a read leaves its masked expectation as a note
    task automatic bus(input logic we, input logic [4:0] adr, input logic [31:0] dat,
                       input logic [31:0] mask, output logic [31:0] rd);
        int t;
        @(posedge sys_clk);
        if (!we) notes.push_back({mask, dat});
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: we ? dat : 32'h0};
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (wbRsp.ack !== 1'b1 && t < 50);
        if (wbRsp.ack !== 1'b1) fails++; // no answer in time
        rd = wbRsp.dat;
        wbReq <= '0;
    endtask : bus

    task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        bus(1'b1, adr, dat, 32'h0, d);
    endtask : wr

    task automatic rdc(input logic [4:0] adr, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] d;
        bus(1'b0, adr, exp, mask, d);
    endtask : rdc

    task automatic waitIrq(input int k);
        int t;
        t = 0;
        while (nIrq < k && t < 400) begin
            @(posedge sys_clk);
            t++;
        end
        chk("result events", k, nIrq);
    endtask : waitIrq

    // monitor: counts events, compares read data with the oldest note
    always @(posedge sys_clk) begin : monitor
        logic [63:0] n;
        if (resultIrq === 1'b1) nIrq++;
        if (overrunIrq === 1'b1) nOvr++;
        if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            chk("read data", n[31:0] & n[63:32], wbRsp.dat & n[63:32]);
        end
    end

    // watchdog, well beyond the several hundred cycles the run needs
    initial begin
        repeat (8000) @(posedge sys_clk);
        fails++;
        stop_test();
    end

    initial begin : main
        logic [31:0] v;
        int t;
        wbReq = '0;
        anaResult = '0;
        pinLevels = '0;
        rst_n = 1'b0;
        seed = 16'h17f9;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(STATUS_OFS, 32'h3, 32'h3);
        wr(CTRL_OFS, 32'h83);
        rdc(5'h18, 32'h0, 32'hffffffff);
        v = 32'h1;
        t = 0;
        // polling reads carry an empty mask; only the final value matters
        while (v[ST_BUSY] !== 1'b0 && t < 100) begin
            bus(1'b0, STATUS_OFS, 32'h0, 32'h0, v);
            t++;
        end
        chk("calibration end", 32'h0, {30'h0, v[1:0]});
        chk("early results", 0, nIrq);
        wr(TIMING_OFS, 32'h0302);
        rdc(TIMING_OFS, 32'h0302, 32'hffff);
        seed = lfsr(seed);
        pinLevels <= {seed, seed[7:0]};
        rdc(PINS_OFS, {8'h0, seed, seed[7:0]}, 32'hffffff);
        seed = lfsr(seed);
        anaResult <= seed[9:0];
        wr(CTRL_OFS, 32'h285);
        rdc(STATUS_OFS, 32'h1, 32'h1);
        chk("group select", 1, anaGroupSel);
        chk("channel", 5, anaChannel);
        waitIrq(1);
        rdc(RESULT_OFS, {22'h0, seed[9:0]}, 32'h3ff);
        rdc(STATUS_OFS, 32'h0, 32'h1);
        repeat (40) @(posedge sys_clk);
        chk("single only", 1, nIrq);
        // continuous with wait-for-read: second result waits in the buffer
        v = {22'h0, seed[9:0]};
        wr(CTRL_OFS, 32'h1a2);
        waitIrq(2);
        seed = lfsr(seed);
        anaResult <= seed[9:0];
        repeat (60) @(posedge sys_clk);
        chk("held results", 2, nIrq);
        rdc(RESULT_OFS, v, 32'h3ff);
        rdc(RESULT_OFS, {22'h0, seed[9:0]}, 32'h3ff);
        wr(CTRL_OFS, 32'h20000);
        // continuous with overrun signalling, then an injected channel
        wr(CTRL_OFS, 32'ha4);
        t = 0;
        while (nOvr == 0 && t < 400) begin
            @(posedge sys_clk);
            t++;
        end
        chk("overrun event", 1, nOvr > 0);
        wr(CTRL_OFS, 32'h9824);
        repeat (40) @(posedge sys_clk);
        rdc(STATUS_OFS, 32'h30, 32'h30);
        rdc(INJECT_OFS, {22'h0, seed[9:0]}, 32'h3ff);
        t = nIrq;
        repeat (40) @(posedge sys_clk);
        chk("continuing", 1, nIrq > t);
        wr(CTRL_OFS, 32'h20000);
        // scan from channel 2 down to 0 gives three results
        repeat (20) @(posedge sys_clk); // let the stopped conversion finish first
        t = nIrq;
        wr(CTRL_OFS, 32'hc2);
        repeat (150) @(posedge sys_clk);
        chk("scan results", t + 3, nIrq);
        t = nIrq;
        wr(CTRL_OFS, 32'he1);
        repeat (100) @(posedge sys_clk);
        chk("scan repeats", 1, nIrq > t + 2);
        wr(CTRL_OFS, 32'h20000);
        // stall protection: an unread result holds off the next conversion
        repeat (20) @(posedge sys_clk);
        rdc(RESULT_OFS, 32'h0, 32'h0);
        t = nIrq;
        v = nOvr;
        wr(CTRL_OFS, 32'h4a4);
        waitIrq(t + 1);
        repeat (60) @(posedge sys_clk);
        chk("stalled results", t + 1, nIrq);
        chk("stall overruns", v, nOvr);
        rdc(RESULT_OFS, {22'h0, seed[9:0]}, 32'h3ff);
        waitIrq(t + 2);
        wr(CTRL_OFS, 32'h20000);
        // second reset calibrates again
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(STATUS_OFS, 32'h3, 32'h3);
        repeat (4) @(posedge sys_clk);
        stop_test();
    end
endmodule : test_adc_sequencer_control

bind adc_sequencer_control adc_sequencer_control_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp), .anaChannel(anaChannel),
    .anaSample(anaSample), .anaConvert(anaConvert), .overrunIrq(overrunIrq),
    .resultIrq(resultIrq), .transferReq(transferReq));
